// File: hhu_uart.v
// Host serial port: baud generator, autobaud, flow control, SLIP, FIFOs
// Summary of operation
// - One port carries Bluetooth and FM traffic
// - Four lines: rx, tx, rts, cts
// - Divider clamped to 9600 bps .. 4 Mbps
// - Autobaud measures start bit, loads divider
// - Host command rewrites divider, applied immediately
// - Reset rate from config load or autobaud
// - Default rate is 115.2 kbaud
// - 1040-byte receive and transmit buffers
// - Buffers reached from internal bus side
// - H4, extended H4 and H5 modes
// - H5 ignores cts and rts
// - XON/XOFF pause and resume transmitter
// - SLIP delimiting and escaping both directions
// - Rx or cts activity raises wake
// - Combined rate error within two percent
// - Integer divider gives listed actual rates
// - Start bit within 1.5 bits of cts
// - Cts high before stop stops next
// - Rts high within half bit of stop
`include "hhu_defines.vh"

module hhu_fifo
(
   input  wire                  i_core_clk,
   input  wire                  i_reset_n,
   input  wire                  i_wr,
   input  wire [8:0]            i_wdata,
   input  wire                  i_rd,
   output wire [8:0]            o_rdata,
   output wire                  o_full,
   output wire                  o_empty,
   output wire [`HHU_PTR_W-1:0] o_count
);
   reg  [8:0]            mem [0:`HHU_DEPTH-1];
   reg  [`HHU_PTR_W-1:0] wr_ptr;
   reg  [`HHU_PTR_W-1:0] rd_ptr;
   reg  [`HHU_PTR_W-1:0] count;
   wire                  do_wr;
   wire                  do_rd;
   genvar                g;

   assign do_wr   = i_wr & (count != `HHU_DEPTH);
   assign do_rd   = i_rd & (count != 11'h000);
   assign o_full  = (count == `HHU_DEPTH);
   assign o_empty = (count == 11'h000);
   assign o_count = count;
   assign o_rdata = mem[rd_ptr];

   // Storage entries
   generate
      for (g = 0; g < `HHU_DEPTH; g = g + 1)
      begin : g_ent
         always @(posedge i_core_clk or negedge i_reset_n)
         begin
            if (!i_reset_n)
               mem[g] <= 9'h000;
            else if (do_wr && (wr_ptr == g))
               mem[g] <= i_wdata;
         end
      end
   endgenerate

   always @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wr_ptr <= 11'h000;
         rd_ptr <= 11'h000;
         count  <= 11'h000;
      end
      else
      begin
         if (do_wr)
            wr_ptr <= (wr_ptr == `HHU_LAST_IDX) ? 11'h000 : wr_ptr + 11'h001;
         if (do_rd)
            rd_ptr <= (rd_ptr == `HHU_LAST_IDX) ? 11'h000 : rd_ptr + 11'h001;
         if (do_wr && !do_rd)
            count <= count + 11'h001;
         else if (do_rd && !do_wr)
            count <= count - 11'h001;
      end
   end
endmodule // hhu_fifo

module hhu_uart
(
   input  wire        i_core_clk,
   input  wire        i_reset_n,
   input  wire        i_rxd,
   output reg         o_txd,
   input  wire        i_cts_n,
   output reg         o_rts_n,
   input  wire [1:0]  i_mode,
   input  wire        i_baud_wr,
   input  wire [15:0] i_baud_div,
   input  wire        i_autobaud_start,
   output reg         o_autobaud_done,
   output wire [15:0] o_baud_div,
   input  wire        i_swfc_en,
   input  wire        i_slip_en,
   input  wire        i_sleep,
   output reg         o_wake,
   input  wire        i_tx_wr,
   input  wire [8:0]  i_tx_data,
   output wire        o_tx_full,
   output wire        o_tx_busy,
   input  wire        i_rx_rd,
   output wire [8:0]  o_rx_data,
   output wire        o_rx_empty,
   output wire [10:0] o_rx_count,
   output reg         o_rx_overrun,
   output reg         o_rx_frame_err,
   input  wire        i_err_clr,
   output reg         o_xoff_hold
);
   reg  [15:0] div;
   reg         rx_s1;
   reg         rx_s2;
   reg         rx_d;
   reg         cts_s1;
   reg         cts_s2;
   reg         cts_d;
   reg         ab_arm;
   reg         ab_meas;
   reg  [15:0] ab_cnt;
   reg  [1:0]  tx_st;
   reg  [15:0] tx_cnt;
   reg  [2:0]  tx_bit;
   reg  [7:0]  tx_sh;
   reg         esc_pend;
   reg  [7:0]  esc_byte;
   reg  [1:0]  rx_st;
   reg  [15:0] rx_cnt;
   reg  [2:0]  rx_bit;
   reg  [7:0]  rx_sh;
   reg         rx_esc;
   reg         rx_wr;
   reg  [8:0]  rx_wdata;
   wire        h5;
   wire [8:0]  tx_head;
   wire        tx_empty;
   wire        rx_full;
   wire        tx_go;
   wire        tx_pop;
   wire        tx_esc;
   wire        rx_fall;
   wire        rx_stop_mid;
   wire [15:0] half_div;

   assign h5         = (i_mode == `HHU_MODE_H5);
   assign o_baud_div = div;
   assign half_div   = {1'b0, div[15:1]};
   assign rx_fall    = rx_d & ~rx_s2;
   assign o_tx_busy  = (tx_st != `HHU_ST_IDLE);

   // Flow gate checked only between characters
   assign tx_go  = (tx_st == `HHU_ST_IDLE) && (esc_pend || !tx_empty) &&
                   (h5 || !cts_s2) && !o_xoff_hold;
   assign tx_pop = tx_go && !esc_pend;
   assign tx_esc = i_slip_en && !tx_head[8] &&
                   ((tx_head[7:0] == `HHU_SLIP_END) || (tx_head[7:0] == `HHU_SLIP_ESC));
   assign rx_stop_mid = (rx_st == `HHU_ST_STOP) && (rx_cnt == 16'h0000);

   hhu_fifo u_tx_fifo
   (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_wr       (i_tx_wr),
      .i_wdata    (i_tx_data),
      .i_rd       (tx_pop),
      .o_rdata    (tx_head),
      .o_full     (o_tx_full),
      .o_empty    (tx_empty),
      .o_count    ()
   );

   hhu_fifo u_rx_fifo
   (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_wr       (rx_wr),
      .i_wdata    (rx_wdata),
      .i_rd       (i_rx_rd),
      .o_rdata    (o_rx_data),
      .o_full     (rx_full),
      .o_empty    (o_rx_empty),
      .o_count    (o_rx_count)
   );

   // Pin synchronisers
   always @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rx_s1  <= 1'b1;
         rx_s2  <= 1'b1;
         rx_d   <= 1'b1;
         // Cts resets to its ready level, no false edge
         cts_s1 <= 1'b0;
         cts_s2 <= 1'b0;
         cts_d  <= 1'b0;
      end
      else
      begin
         rx_s1  <= i_rxd;
         rx_s2  <= rx_s1;
         rx_d   <= rx_s2;
         cts_s1 <= i_cts_n;
         cts_s2 <= cts_s1;
         cts_d  <= cts_s2;
      end
   end

   // Divider select and autobaud
   always @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         div             <= `HHU_DIV_RST;
         ab_arm          <= 1'b0;
         ab_meas         <= 1'b0;
         ab_cnt          <= 16'h0000;
         o_autobaud_done <= 1'b0;
      end
      else
      begin
         if (i_baud_wr)
         begin
            // Clamp keeps the rate inside the supported span
            if (i_baud_div < `HHU_DIV_MIN)
               div <= `HHU_DIV_MIN;
            else if (i_baud_div > `HHU_DIV_MAX)
               div <= `HHU_DIV_MAX;
            else
               div <= i_baud_div;
         end
         if (i_autobaud_start)
         begin
            ab_arm          <= 1'b1;
            ab_meas         <= 1'b0;
            o_autobaud_done <= 1'b0;
         end
         else if (ab_arm && !ab_meas && rx_fall)
         begin
            ab_meas <= 1'b1;
            ab_cnt  <= 16'h0001;
         end
         else if (ab_meas && !rx_s2)
         begin
            if (ab_cnt != 16'hFFFF)
               ab_cnt <= ab_cnt + 16'h0001;
         end
         else if (ab_meas)
         begin
            // Start bit width becomes the bit period
            ab_arm          <= 1'b0;
            ab_meas         <= 1'b0;
            o_autobaud_done <= 1'b1;
            if (ab_cnt < `HHU_DIV_MIN)
               div <= `HHU_DIV_MIN;
            else if (ab_cnt > `HHU_DIV_MAX)
               div <= `HHU_DIV_MAX;
            else
               div <= ab_cnt;
         end
      end
   end

   // Transmitter
   always @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         tx_st    <= `HHU_ST_IDLE;
         tx_cnt   <= 16'h0000;
         tx_bit   <= 3'h0;
         tx_sh    <= 8'h00;
         esc_pend <= 1'b0;
         esc_byte <= 8'h00;
         o_txd    <= 1'b1;
      end
      else
      begin
         case (tx_st)
            `HHU_ST_IDLE:
            begin
               o_txd <= 1'b1;
               if (tx_go)
               begin
                  tx_st  <= `HHU_ST_START;
                  tx_cnt <= div - 16'h0001;
                  o_txd  <= 1'b0;
                  if (esc_pend)
                  begin
                     tx_sh    <= esc_byte;
                     esc_pend <= 1'b0;
                  end
                  else if (tx_esc)
                  begin
                     tx_sh    <= `HHU_SLIP_ESC;
                     esc_pend <= 1'b1;
                     esc_byte <= (tx_head[7:0] == `HHU_SLIP_END) ? `HHU_SLIP_ESC_END : `HHU_SLIP_ESC_ESC;
                  end
                  else
                     tx_sh <= tx_head[7:0];
               end
            end
            `HHU_ST_START:
            begin
               if (tx_cnt == 16'h0000)
               begin
                  tx_st  <= `HHU_ST_DATA;
                  tx_cnt <= div - 16'h0001;
                  tx_bit <= 3'h0;
                  o_txd  <= tx_sh[0];
               end
               else
                  tx_cnt <= tx_cnt - 16'h0001;
            end
            `HHU_ST_DATA:
            begin
               if (tx_cnt == 16'h0000)
               begin
                  tx_cnt <= div - 16'h0001;
                  if (tx_bit == 3'h7)
                  begin
                     tx_st <= `HHU_ST_STOP;
                     o_txd <= 1'b1;
                  end
                  else
                  begin
                     tx_bit <= tx_bit + 3'h1;
                     tx_sh  <= {1'b0, tx_sh[7:1]};
                     o_txd  <= tx_sh[1];
                  end
               end
               else
                  tx_cnt <= tx_cnt - 16'h0001;
            end
            default:
            begin
               if (tx_cnt == 16'h0000)
                  tx_st <= `HHU_ST_IDLE;
               else
                  tx_cnt <= tx_cnt - 16'h0001;
            end
         endcase
      end
   end

   // Receiver
   always @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rx_st          <= `HHU_ST_IDLE;
         rx_cnt         <= 16'h0000;
         rx_bit         <= 3'h0;
         rx_sh          <= 8'h00;
         rx_esc         <= 1'b0;
         rx_wr          <= 1'b0;
         rx_wdata       <= 9'h000;
         o_rx_overrun   <= 1'b0;
         o_rx_frame_err <= 1'b0;
         o_xoff_hold    <= 1'b0;
      end
      else
      begin
         rx_wr <= 1'b0;
         if (i_err_clr)
         begin
            o_rx_overrun   <= 1'b0;
            o_rx_frame_err <= 1'b0;
         end
         if (!i_swfc_en)
            o_xoff_hold <= 1'b0;
         case (rx_st)
            `HHU_ST_IDLE:
            begin
               if (rx_fall)
               begin
                  rx_st  <= `HHU_ST_START;
                  rx_cnt <= half_div;
               end
            end
            `HHU_ST_START:
            begin
               if (rx_cnt == 16'h0000)
               begin
                  rx_st  <= rx_s2 ? `HHU_ST_IDLE : `HHU_ST_DATA;
                  rx_cnt <= div - 16'h0001;
                  rx_bit <= 3'h0;
               end
               else
                  rx_cnt <= rx_cnt - 16'h0001;
            end
            `HHU_ST_DATA:
            begin
               if (rx_cnt == 16'h0000)
               begin
                  rx_sh  <= {rx_s2, rx_sh[7:1]};
                  rx_cnt <= div - 16'h0001;
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == 3'h7)
                     rx_st <= `HHU_ST_STOP;
               end
               else
                  rx_cnt <= rx_cnt - 16'h0001;
            end
            default:
            begin
               if (rx_cnt != 16'h0000)
                  rx_cnt <= rx_cnt - 16'h0001;
               else
               begin
                  rx_st <= `HHU_ST_IDLE;
                  if (!rx_s2)
                     o_rx_frame_err <= 1'b1;
                  else if (i_swfc_en && (rx_sh == `HHU_XOFF))
                     o_xoff_hold <= 1'b1;
                  else if (i_swfc_en && (rx_sh == `HHU_XON))
                     o_xoff_hold <= 1'b0;
                  else if (i_slip_en && rx_esc)
                  begin
                     rx_esc   <= 1'b0;
                     rx_wr    <= 1'b1;
                     rx_wdata <= {1'b0, (rx_sh == `HHU_SLIP_ESC_END) ? `HHU_SLIP_END :
                                 (rx_sh == `HHU_SLIP_ESC_ESC) ? `HHU_SLIP_ESC : rx_sh};
                  end
                  else if (i_slip_en && (rx_sh == `HHU_SLIP_ESC))
                     rx_esc <= 1'b1;
                  else
                  begin
                     rx_wr    <= 1'b1;
                     rx_wdata <= {i_slip_en && (rx_sh == `HHU_SLIP_END), rx_sh};
                  end
                  if (rx_s2 && rx_full)
                     o_rx_overrun <= 1'b1;
               end
            end
         endcase
      end
   end

   // Request-to-send and wake
   always @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_rts_n <= 1'b1;
         o_wake  <= 1'b0;
      end
      else
      begin
         // Limit leaves room for characters already in flight
         if (h5)
            o_rts_n <= 1'b1;
         else
            o_rts_n <= (o_rx_count >= `HHU_RTS_LIMIT);
         if (!i_sleep)
            o_wake <= 1'b0;
         else if ((rx_s2 != rx_d) || (cts_s2 != cts_d))
            o_wake <= 1'b1;
      end
   end
endmodule // hhu_uart

// File: hhu_defines.vh
// Constants for the host serial port
`ifndef HHU_DEFINES_VH
`define HHU_DEFINES_VH
`define HHU_CLK_HZ        200000000
`define HHU_BAUD_DEFAULT  115200
`define HHU_BAUD_MIN      9600
`define HHU_BAUD_MAX      4000000
`define HHU_DIV_RST       16'h06C8
`define HHU_DIV_MIN       16'h0032
`define HHU_DIV_MAX       16'h5161
`define HHU_DEPTH         1040
`define HHU_PTR_W         11
`define HHU_LAST_IDX      11'h40F
`define HHU_RTS_LIMIT     11'h400
`define HHU_MODE_H4       2'h0
`define HHU_MODE_EH4      2'h1
`define HHU_MODE_H5       2'h2
`define HHU_XON           8'h11
`define HHU_XOFF          8'h13
`define HHU_SLIP_END      8'hC0
`define HHU_SLIP_ESC      8'hDB
`define HHU_SLIP_ESC_END  8'hDC
`define HHU_SLIP_ESC_ESC  8'hDD
`define HHU_ST_IDLE       2'h0
`define HHU_ST_START      2'h1
`define HHU_ST_DATA       2'h2
`define HHU_ST_STOP       2'h3
`endif

// File: hhu_uart_assertions.sv
// Pin-level checks bound to the host serial port
`include "hhu_defines.vh"
module hhu_uart_assertions
(
   input wire        i_core_clk,
   input wire        i_reset_n,
   input wire        i_cts_n,
   input wire [1:0]  i_mode,
   input wire        i_baud_wr,
   input wire [15:0] i_baud_div,
   input wire        i_sleep,
   input wire        i_swfc_en,
   input wire        i_err_clr,
   input wire        o_txd,
   input wire        o_rts_n,
   input wire [15:0] o_baud_div,
   input wire        o_wake,
   input wire        o_tx_busy,
   input wire [10:0] o_rx_count,
   input wire        o_rx_empty,
   input wire        o_rx_frame_err,
   input wire        o_xoff_hold
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   function automatic logic [15:0] lim(input logic [15:0] d);
      return d < `HHU_DIV_MIN ? `HHU_DIV_MIN : d > `HHU_DIV_MAX ? `HHU_DIV_MAX : d;
   endfunction

   div_load_a: assert property (i_baud_wr |=> o_baud_div == lim($past(i_baud_div)))
      else $error("divider load wrong");
   idle_high_a: assert property (!o_tx_busy |-> o_txd)
      else $error("tx line low while idle");
   start_bit_a: assert property ($rose(o_tx_busy) |-> !o_txd [*8])
      else $error("start bit too short");
   cts_block_a: assert property ((i_cts_n && i_mode != `HHU_MODE_H5) [*3] ##0 !o_tx_busy |=> o_txd)
      else $error("start while cts high");
   h5_rts_a: assert property (i_mode == `HHU_MODE_H5 |=> o_rts_n)
      else $error("rts low in three-wire mode");
   rts_room_a: assert property ((i_mode != `HHU_MODE_H5 && o_rx_count < `HHU_RTS_LIMIT) [*3] |-> !o_rts_n)
      else $error("rts high with room left");
   wake_set_a: assert property (i_sleep && $changed(i_cts_n) ##1 i_sleep [*5] |-> o_wake)
      else $error("no wake on cts activity");
   wake_clr_a: assert property (!i_sleep |=> !o_wake)
      else $error("wake held while awake");
   xoff_clr_a: assert property (!i_swfc_en |=> !o_xoff_hold)
      else $error("tx hold without flow control");
   ferr_keep_a: assert property (o_rx_frame_err && !i_err_clr |=> o_rx_frame_err)
      else $error("frame error lost");
   empty_cnt_a: assert property (o_rx_empty == (o_rx_count == 11'h000))
      else $error("empty flag disagrees with count");
endmodule // hhu_uart_assertions

bind hhu_uart hhu_uart_assertions hhu_uart_assertions_i (.*);

// File: hhu_host.sv
// Host side serial model: sends and decodes 8N1 frames
module hhu_host
(
   input  wire  i_core_clk,
   input  wire  i_txd,
   output logic o_rxd,
   output logic o_cts_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int         bit_len = 50;  // Same rate as device
   logic [7:0] got[$];

   // Host never looks at rts; three-wire use
   initial
   begin
      o_rxd = 1'b1;  // Idle high
      o_cts_n = 1'b0;
   end

   task automatic set_cts(input logic v);
      o_cts_n <= v;  // Raised well before stop midpoint
   endtask

   task automatic send(input logic [7:0] d, input logic stp);
      logic [9:0] f;
      f = {stp, d, 1'b0};  // Start, LSB first, stop
      for (int i = 0; i < 11; i++)
      begin
         o_rxd <= i < 10 ? f[i] : 1'b1;
         repeat (bit_len) @(posedge i_core_clk);
      end
   endtask

   always @(negedge i_txd)
   begin : rx_frame
      logic [7:0] d;
      repeat (bit_len / 2) @(posedge i_core_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (bit_len) @(posedge i_core_clk);
         d[i] = i_txd;  // LSB first
      end
      repeat (bit_len) @(posedge i_core_clk);
      if (i_txd === 1'b1)
         got.push_back(d);  // Valid stop bit
   end
endmodule // hhu_host

// File: hhu_uart_test.sv
// Self-checking bench for the host serial port
module hhu_uart_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_core_clk, i_reset_n = 0, i_rxd, i_cts_n, i_baud_wr = 0, i_autobaud_start = 0;
   logic        i_swfc_en = 0, i_slip_en = 0, i_sleep = 0, i_tx_wr = 0, i_rx_rd = 0, i_err_clr = 0;
   logic [1:0]  i_mode = 0;
   logic [15:0] i_baud_div = 0;
   logic [8:0]  i_tx_data = 0;
   logic        o_txd, o_rts_n, o_autobaud_done, o_wake, o_tx_full, o_tx_busy, o_rx_empty;
   logic        o_rx_overrun, o_rx_frame_err, o_xoff_hold;
   logic [15:0] o_baud_div;
   logic [8:0]  o_rx_data;
   logic [10:0] o_rx_count;
   int          bad_count = 0;
   int          n_checks = 0;

   hhu_uart hhu_uart_i (.*);
   hhu_host hhu_host_i (.i_core_clk(i_core_clk), .i_txd(o_txd), .o_rxd(i_rxd), .o_cts_n(i_cts_n));

   initial
   begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   task automatic summarize;
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask

   task automatic tmo(input logic ok);
      if (ok !== 1'b1)
      begin
         bad_count++;
         summarize;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask

   function automatic logic [15:0] lim(input logic [15:0] d);
      return d < 16'h0032 ? 16'h0032 : d > 16'h5161 ? 16'h5161 : d;
   endfunction

   task automatic bw(input logic [15:0] v);
      i_baud_wr <= 1'b1;
      i_baud_div <= v;
      tick(1);
      i_baud_wr <= 1'b0;
      tick(2);
      chk("div", lim(v), o_baud_div);
   endtask

   task automatic txw(input logic [8:0] d);
      i_tx_wr <= 1'b1;
      i_tx_data <= d;
      tick(1);
      i_tx_wr <= 1'b0;
      tick(1);
   endtask

   task automatic txq(input logic [7:0] e);
      for (int i = 0; i < 2000 && hhu_host_i.got.size() == 0; i++) tick(1);
      tmo(hhu_host_i.got.size() != 0);
      chk("tx byte", {8'h00, e}, {8'h00, hhu_host_i.got.pop_front()});
   endtask

   task automatic rxp(input logic [8:0] e);
      for (int i = 0; i < 2000 && o_rx_empty !== 1'b0; i++) tick(1);
      tmo(o_rx_empty === 1'b0);
      chk("rx byte", {7'h00, e}, {7'h00, o_rx_data});
      i_rx_rd <= 1'b1;
      tick(1);
      i_rx_rd <= 1'b0;
      tick(2);
   endtask

   initial
   begin
      logic [7:0]  d[8];
      logic [15:0] bt[4];
      int          t;
      void'($urandom(54));
      bt = '{16'h000A, 16'h9000, 16'h0064, 16'h0032};
      tick(16);
      i_reset_n <= 1'b1;
      chk("div reset", 16'h06C8, o_baud_div);
      tick(3);
      chk("rts", 16'h0000, 16'(o_rts_n));
      bw(16'($urandom));
      foreach (bt[k]) bw(bt[k]);
      i_mode <= 2'($urandom_range(1, 0));
      foreach (d[k])
      begin
         d[k] = 8'($urandom);
         txw({1'b0, d[k]});
      end
      foreach (d[k]) txq(d[k]);
      foreach (d[k])
      begin
         d[k] = 8'($urandom);
         hhu_host_i.send(d[k], 1'b1);
      end
      foreach (d[k]) rxp({1'b0, d[k]});
      chk("overrun", 16'h0000, 16'(o_rx_overrun));
      i_mode <= 2'h0;
      i_slip_en <= 1'b1;
      txw(9'h0C0);
      txw(9'h1C0);
      txq(8'hDB);
      txq(8'hDC);
      txq(8'hC0);
      hhu_host_i.send(8'hDB, 1'b1);
      hhu_host_i.send(8'hDD, 1'b1);
      hhu_host_i.send(8'hC0, 1'b1);
      rxp(9'h0DB);
      rxp(9'h1C0);
      i_slip_en <= 1'b0;
      i_swfc_en <= 1'b1;
      hhu_host_i.send(8'h13, 1'b1);
      chk("xoff", 16'h0001, 16'(o_xoff_hold));
      txw(9'h05A);
      tick(1000);
      chk("paused", 16'h0000, 16'(hhu_host_i.got.size()));
      hhu_host_i.send(8'h11, 1'b1);
      txq(8'h5A);
      chk("consumed", 16'h0001, 16'(o_rx_empty));
      i_swfc_en <= 1'b0;
      txw(9'h0A5);
      txw(9'h03C);
      for (t = 0; t < 200 && o_txd !== 1'b0; t++) tick(1);
      tmo(t < 200);
      tick(100);
      hhu_host_i.set_cts(1'b1);
      tick(1500);
      txq(8'hA5);
      chk("held", 16'h0000, 16'(hhu_host_i.got.size()));
      hhu_host_i.set_cts(1'b0);
      for (t = 0; t < 200 && o_txd !== 1'b0; t++) tick(1);
      tmo(t < 200);
      chk("cts delay", 16'h0001, 16'(t <= 75));
      txq(8'h3C);
      hhu_host_i.send(8'h55, 1'b0);
      chk("frame err", 16'h0001, 16'(o_rx_frame_err));
      chk("dropped", 16'h0001, 16'(o_rx_empty));
      i_err_clr <= 1'b1;
      tick(1);
      i_err_clr <= 1'b0;
      tick(2);
      chk("err clr", 16'h0000, 16'(o_rx_frame_err));
      i_mode <= 2'h2;
      hhu_host_i.set_cts(1'b1);
      txw(9'h0E7);
      txq(8'hE7);
      chk("h5 rts", 16'h0001, 16'(o_rts_n));
      hhu_host_i.set_cts(1'b0);
      tick(4);
      i_mode <= 2'h0;
      i_sleep <= 1'b1;
      tick(2);
      hhu_host_i.set_cts(1'b1);
      tick(8);
      chk("wake", 16'h0001, 16'(o_wake));
      i_sleep <= 1'b0;
      hhu_host_i.set_cts(1'b0);
      tick(3);
      chk("wake clr", 16'h0000, 16'(o_wake));
      i_autobaud_start <= 1'b1;
      tick(1);
      i_autobaud_start <= 1'b0;
      hhu_host_i.bit_len = 100;
      hhu_host_i.send(8'h01, 1'b1);
      for (t = 0; t < 500 && o_autobaud_done !== 1'b1; t++) tick(1);
      tmo(t < 500);
      chk("ab done", 16'h0001, 16'(o_autobaud_done));
      chk("autobaud", 16'h0001, 16'(o_baud_div >= 98 && o_baud_div <= 102));
      hhu_host_i.set_cts(1'b1);
      tick(4);
      i_tx_wr <= 1'b1;
      for (int k = 0; k < 1041; k++)
      begin
         i_tx_data <= 9'($urandom);
         tick(1);
         if (k == 1039)
            chk("tx not full", 16'h0000, 16'(o_tx_full));
      end
      i_tx_wr <= 1'b0;
      chk("tx full", 16'h0001, 16'(o_tx_full));
      chk("tx held", 16'h0000, 16'(o_tx_busy));
      i_reset_n <= 1'b0;
      tick(4);
      i_reset_n <= 1'b1;
      tick(3);
      chk("tx empty", 16'h0000, 16'(o_tx_full));
      chk("div reset", 16'h06C8, o_baud_div);
      chk("rts", 16'h0000, 16'(o_rts_n));
      chk("rx empty", 16'h0001, 16'(o_rx_empty));
      summarize;
   end
endmodule // hhu_uart_test
